// [hdl/tpm_byte_counter.sv]
// One counter byte with its match buffer
`timescale 1ns/1ps
`default_nettype none
`include "tpm_params.svh"

module tpm_byte_counter (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic match_in,
    input wire logic [7:0] match_data_in,
    output tpm_pkg::tpm_cnt_stat_t stat_out
);

    logic [7:0] count_r;
    logic [7:0] buffer_r;

    // ==========================================================
    // Counter
    // Stop and match both park at zero, stop wins over a tick
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_r <= `TPM_BYTE_RST;
        end else if (!run_in || match_in) begin
            count_r <= `TPM_BYTE_RST;
        end else if (tick_in) begin
            count_r <= count_r + `TPM_BYTE_ONE;
        end
    end

    // ==========================================================
    // Match buffer
    // Reload at a match while running, and on every cycle while stopped,
    // so a new period never cuts the one in progress short
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            buffer_r <= `TPM_BYTE_RST;
        end else if (!run_in) begin
            buffer_r <= match_data_in;
        end else if (match_in) begin
            buffer_r <= match_data_in;
        end
    end

    // Status to the parent
    assign stat_out.count = count_r;
    assign stat_out.buffer = buffer_r;
    assign stat_out.equal = (count_r == buffer_r);

endmodule
`default_nettype wire

// [hdl/tpm_params.svh]
// Timer 0 constants: register indices, field positions, reset values
`ifndef TPM_PARAMS_SVH
`define TPM_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define TPM_IDX_CTRL 16'hFE10
`define TPM_IDX_PRESCALER 16'hFE11
`define TPM_IDX_CNT_LO 16'hFE12
`define TPM_IDX_CNT_HI 16'hFE13
`define TPM_IDX_MDATA_LO 16'hFE14
`define TPM_IDX_MDATA_HI 16'hFE15
`define TPM_IDX_CAP_LO 16'hFE16
`define TPM_IDX_CAP_HI 16'hFE17
`define TPM_IDX_IRQ_STATUS 16'hFE20
`define TPM_IDX_IRQ_MASK 16'hFE21
`define TPM_IDX_EVSEL 16'hFE22

// ==========================================================
// Interrupt status and mask bit positions
`define TPM_IRQ_LOW 0
`define TPM_IRQ_HIGH 1
`define TPM_IRQ_CAP 2

// ==========================================================
// Reset values and byte constants
`define TPM_CTRL_RST 8'h00
`define TPM_BYTE_RST 8'h00
`define TPM_EVSEL_RST 2'h3
`define TPM_IRQ_RST 3'h0
`define TPM_BYTE_MAX 8'hFF
`define TPM_BYTE_ONE 8'h01
`define TPM_WORD_RST 32'h0000_0000
`define TPM_SYNC_RST 3'h0
`define TPM_BIT_RST 1'b0

`endif

// [hdl/tpm_pkg.sv]
// Timer 0 shared types
package tpm_pkg;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic high_run;
        logic low_run;
        logic length_select;
        logic low_clock_select;
        logic high_match_flag;
        logic high_irq_enable;
        logic low_match_flag;
        logic low_irq_enable;
    } tpm_ctrl_t;

    // State reported by one counter byte
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] buffer;
        logic equal;
    } tpm_cnt_stat_t;

    // Bus slave handshake
    typedef enum logic [1:0] {
        TPM_BUS_IDLE = 2'b01,
        TPM_BUS_ACK = 2'b10
    } tpm_bus_state_t;

endpackage

// [hdl/tpm_timer0.sv]
// Timer 0: prescaler, two counter bytes, capture and Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "tpm_params.svh"

module tpm_timer0 (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [17:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic ext_event_in_a_in,
    input wire logic ext_event_in_b_in,
    output logic low_irq_req_out,
    output logic high_irq_req_out,
    output logic irq_out
);

    // ==========================================================
    // Declarations
    tpm_pkg::tpm_bus_state_t bus_state_r;
    tpm_pkg::tpm_ctrl_t ctrl_r;
    tpm_pkg::tpm_ctrl_t wr_ctrl;
    tpm_pkg::tpm_cnt_stat_t lo_stat;
    tpm_pkg::tpm_cnt_stat_t hi_stat;
    logic [31:0] readdata_r;
    logic [31:0] read_nxt;
    logic [7:0] prescaler_match_r;
    logic [7:0] pre_count_r;
    logic [7:0] match_data_low_r;
    logic [7:0] match_data_high_r;
    logic [7:0] capture_low_r;
    logic [7:0] capture_high_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_set;
    logic [1:0] evsel_r;
    logic [1:0] ev_pin;
    logic [2:0] ev_sync_r [2];
    logic [1:0] ev_level_r;
    logic [1:0] ev_detect;
    logic ext_det;
    logic bus_req;
    logic bus_fire;
    logic wr_fire;
    logic [15:0] wr_index;
    logic wr_ctrl_hit;
    logic wr_pre_hit;
    logic pre_tick;
    logic low_tick;
    logic high_tick;
    logic low_carry;
    logic match16;
    logic low_match;
    logic high_match;

    // ==========================================================
    // Bus slave handshake
    // One wait cycle on every access: read data are registered
    // from the decoded address, which keeps the mux off the bus
    assign bus_req = avs_read_in || avs_write_in;
    assign avs_waitrequest_out = bus_req && (bus_state_r == tpm_pkg::TPM_BUS_IDLE);
    assign bus_fire = bus_req && (bus_state_r == tpm_pkg::TPM_BUS_ACK);
    assign wr_fire = bus_fire && avs_write_in && avs_byteenable_in[0];
    assign wr_index = avs_address_in[17:2];
    assign wr_ctrl = tpm_pkg::tpm_ctrl_t'(avs_writedata_in[7:0]);
    assign wr_ctrl_hit = wr_fire && (wr_index == `TPM_IDX_CTRL);
    assign wr_pre_hit = wr_fire && (wr_index == `TPM_IDX_PRESCALER);

    // Handshake state: idle, then one answer cycle
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_state_r <= tpm_pkg::TPM_BUS_IDLE;
        end else begin
            unique case (bus_state_r)
                tpm_pkg::TPM_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= tpm_pkg::TPM_BUS_ACK;
                    end
                end
                tpm_pkg::TPM_BUS_ACK: begin
                    bus_state_r <= tpm_pkg::TPM_BUS_IDLE;
                end
                default: begin
                    bus_state_r <= tpm_pkg::TPM_BUS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Read decode
    // Unmapped addresses read as zero; upper bits always zero
    always_comb begin
        read_nxt = 32'h0000_0000;
        if (avs_address_in[1:0] == 2'h0) begin
            unique case (wr_index)
                `TPM_IDX_CTRL: read_nxt[7:0] = ctrl_r;
                `TPM_IDX_PRESCALER: read_nxt[7:0] = prescaler_match_r;
                `TPM_IDX_CNT_LO: read_nxt[7:0] = lo_stat.count;
                `TPM_IDX_CNT_HI: read_nxt[7:0] = hi_stat.count;
                `TPM_IDX_MDATA_LO: read_nxt[7:0] = match_data_low_r;
                `TPM_IDX_MDATA_HI: read_nxt[7:0] = match_data_high_r;
                `TPM_IDX_CAP_LO: read_nxt[7:0] = capture_low_r;
                `TPM_IDX_CAP_HI: read_nxt[7:0] = capture_high_r;
                `TPM_IDX_IRQ_STATUS: read_nxt[2:0] = irq_status_r;
                `TPM_IDX_IRQ_MASK: read_nxt[2:0] = irq_mask_r;
                `TPM_IDX_EVSEL: read_nxt[1:0] = evsel_r;
                default: read_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the wait cycle, stable at the answer edge
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            readdata_r <= `TPM_WORD_RST;
        end else if (avs_read_in && bus_state_r == tpm_pkg::TPM_BUS_IDLE) begin
            readdata_r <= read_nxt;
        end
    end

    assign avs_readdata_out = readdata_r;

    // ==========================================================
    // Control register
    // Flags: hardware set beats a software clear in the same cycle.
    // Writing 0 clears a flag, writing 1 leaves it as it is.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_r <= tpm_pkg::tpm_ctrl_t'(`TPM_CTRL_RST);
        end else begin
            if (wr_ctrl_hit) begin
                ctrl_r.high_run <= wr_ctrl.high_run;
                ctrl_r.low_run <= wr_ctrl.low_run;
                ctrl_r.length_select <= wr_ctrl.length_select;
                ctrl_r.low_clock_select <= wr_ctrl.low_clock_select;
                ctrl_r.high_irq_enable <= wr_ctrl.high_irq_enable;
                ctrl_r.low_irq_enable <= wr_ctrl.low_irq_enable;
            end
            ctrl_r.high_match_flag <= high_match ||
                (ctrl_r.high_match_flag && !(wr_ctrl_hit && !wr_ctrl.high_match_flag));
            ctrl_r.low_match_flag <= low_match ||
                (ctrl_r.low_match_flag && !(wr_ctrl_hit && !wr_ctrl.low_match_flag));
        end
    end

    // Interrupt requests toward the core's vectors
    assign low_irq_req_out = ctrl_r.low_match_flag && ctrl_r.low_irq_enable;
    assign high_irq_req_out = ctrl_r.high_match_flag && ctrl_r.high_irq_enable;

    // ==========================================================
    // Writable data registers
    // Counter and capture indices have no write path at all
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prescaler_match_r <= `TPM_BYTE_RST;
        end else if (wr_pre_hit) begin
            prescaler_match_r <= avs_writedata_in[7:0];
        end
    end

    // Match data, low byte
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_data_low_r <= `TPM_BYTE_RST;
        end else if (wr_fire && wr_index == `TPM_IDX_MDATA_LO) begin
            match_data_low_r <= avs_writedata_in[7:0];
        end
    end

    // Match data, high byte
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            match_data_high_r <= `TPM_BYTE_RST;
        end else if (wr_fire && wr_index == `TPM_IDX_MDATA_HI) begin
            match_data_high_r <= avs_writedata_in[7:0];
        end
    end

    // Event input selection
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evsel_r <= `TPM_EVSEL_RST;
        end else if (wr_fire && wr_index == `TPM_IDX_EVSEL) begin
            evsel_r <= avs_writedata_in[1:0];
        end
    end

    // ==========================================================
    // Prescaler
    // A setting write parks the count at zero; the tick of that
    // cycle is suppressed so no short period leaks out
    assign pre_tick = (pre_count_r == prescaler_match_r) && !wr_pre_hit;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_count_r <= `TPM_BYTE_RST;
        end else if (wr_pre_hit) begin
            pre_count_r <= `TPM_BYTE_RST;
        end else if (pre_count_r == prescaler_match_r) begin
            pre_count_r <= `TPM_BYTE_RST;
        end else begin
            pre_count_r <= pre_count_r + `TPM_BYTE_ONE;
        end
    end

    // ==========================================================
    // External event inputs
    // Three stages; a level is accepted once stages two and three
    // agree, which filters single-cycle glitches on the pins
    assign ev_pin = {ext_event_in_b_in, ext_event_in_a_in};

    for (genvar i = 0; i < 2; i++) begin : g_ev
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ev_sync_r[i] <= `TPM_SYNC_RST;
            end else begin
                ev_sync_r[i] <= {ev_sync_r[i][1:0], ev_pin[i]};
            end
        end

        // Accepted level
        always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ev_level_r[i] <= `TPM_BIT_RST;
            end else if (ev_sync_r[i][1] == ev_sync_r[i][2]) begin
                ev_level_r[i] <= ev_sync_r[i][1];
            end
        end

        // Rising edge of the accepted level, one cycle
        assign ev_detect[i] = (ev_sync_r[i][1] == ev_sync_r[i][2]) &&
            ev_sync_r[i][2] && !ev_level_r[i];
    end

    assign ext_det = |(ev_detect & evsel_r);

    // ==========================================================
    // Count clocks and match signals
    // In word mode the high byte advances on the low byte's wrap
    assign low_tick = ctrl_r.low_clock_select ? ext_det : pre_tick;
    assign low_carry = low_tick && (lo_stat.count == `TPM_BYTE_MAX);
    assign high_tick = ctrl_r.length_select ? (low_carry && !match16) : pre_tick;

    // Word match needs all sixteen bits equal on a low tick
    assign match16 = ctrl_r.length_select && ctrl_r.low_run && low_tick &&
        lo_stat.equal && hi_stat.equal;

    // Byte matches, or both at once from the word match
    assign low_match = ctrl_r.length_select ? match16 :
        (low_tick && ctrl_r.low_run && lo_stat.equal);
    assign high_match = ctrl_r.length_select ? match16 :
        (high_tick && ctrl_r.high_run && hi_stat.equal);

    // ==========================================================
    // Counter bytes
    tpm_byte_counter u_low (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(ctrl_r.low_run),
        .tick_in(low_tick),
        .match_in(low_match),
        .match_data_in(match_data_low_r),
        .stat_out(lo_stat)
    );

    tpm_byte_counter u_high (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(ctrl_r.high_run),
        .tick_in(high_tick),
        .match_in(high_match),
        .match_data_in(match_data_high_r),
        .stat_out(hi_stat)
    );

    // ==========================================================
    // Capture registers
    // Counts are taken before this cycle's increment or clear.
    // Bus writes never reach them.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            capture_low_r <= `TPM_BYTE_RST;
        end else if (ext_det) begin
            capture_low_r <= lo_stat.count;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            capture_high_r <= `TPM_BYTE_RST;
        end else if (ext_det) begin
            capture_high_r <= hi_stat.count;
        end
    end

    // ==========================================================
    // Sticky interrupt status and mask
    // Write one to clear; a new event in the same cycle wins
    assign irq_set[`TPM_IRQ_LOW] = low_match;
    assign irq_set[`TPM_IRQ_HIGH] = high_match;
    assign irq_set[`TPM_IRQ_CAP] = ext_det;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_status_r <= `TPM_IRQ_RST;
        end else if (wr_fire && wr_index == `TPM_IDX_IRQ_STATUS) begin
            irq_status_r <= (irq_status_r & ~avs_writedata_in[2:0]) | irq_set;
        end else begin
            irq_status_r <= irq_status_r | irq_set;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_mask_r <= `TPM_IRQ_RST;
        end else if (wr_fire && wr_index == `TPM_IDX_IRQ_MASK) begin
            irq_mask_r <= avs_writedata_in[2:0];
        end
    end

    // Level output, high while any enabled status bit is set
    assign irq_out = |(irq_status_r & irq_mask_r);

endmodule
`default_nettype wire

// [verif/tpm_timer0_bench.sv]
// Self-checking bench for timer 0
`timescale 1ns/1ps
`default_nettype none
`include "tpm_params.svh"
module tpm_timer0_bench;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [17:0] avs_address_in = 18'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'h1;
    logic ext_a = 1'b0;
    logic ext_b = 1'b0;
    wire logic [31:0] rdata;
    wire logic wreq;
    wire logic low_irq;
    wire logic high_irq;
    wire logic irq;
    logic [7:0] rd;
    int error_cnt = 0;
    int n_compared = 0;
    time tw;
    time tr;
    time t0;

    // ==========
    // Clock and device
    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    tpm_timer0 u_tpm_timer0 (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .ext_event_in_a_in(ext_a), .ext_event_in_b_in(ext_b),
        .low_irq_req_out(low_irq), .high_irq_req_out(high_irq), .irq_out(irq)
    );

    // ==========
    // Common tasks
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Holds the request until waitrequest is seen low, then one idle cycle
    // so the next call never reassigns a strobe in the same time step
    task automatic bx(input logic w, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rd = rdata[7:0];
        tw = $time;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            stop_test();
        end
        @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bx(1'b1, {idx, 2'b00}, d);
    endtask
    task automatic rc(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        bx(1'b0, {idx, 2'b00}, 8'h00);
        chk(nm, {24'h0, exp}, {24'h0, rd});
    endtask
    // Waits for a request level; time of the sampling edge lands in tr
    task automatic wait_irq(input logic hi);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while ((hi ? high_irq : low_irq) !== 1'b1 && n < 2000);
        tr = $time;
        if (n >= 2000) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic pulse(input logic pin_b);
        if (pin_b) ext_b <= 1'b1;
        else ext_a <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        ext_a <= 1'b0;
        ext_b <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask

    // ==========
    // Scenarios
    task automatic t_reset;
        rc("control", `TPM_IDX_CTRL, 8'h00);
        rc("prescaler", `TPM_IDX_PRESCALER, 8'h00);
        rc("count low", `TPM_IDX_CNT_LO, 8'h00);
        rc("count high", `TPM_IDX_CNT_HI, 8'h00);
        rc("data low", `TPM_IDX_MDATA_LO, 8'h00);
        rc("data high", `TPM_IDX_MDATA_HI, 8'h00);
        rc("mask", `TPM_IDX_IRQ_MASK, 8'h00);
        rc("event select", `TPM_IDX_EVSEL, 8'h03);
        bx(1'b0, {`TPM_IDX_CTRL, 2'b01}, 8'h00);
        chk("unmapped", 32'h0, {24'h0, rd});
    endtask
    // Match period 1 tick, then a slower prescaler, then a buffered reload
    task automatic t_prescale;
        wr(`TPM_IDX_PRESCALER, 8'h03);
        wr(`TPM_IDX_CTRL, 8'h41);
        wait_irq(1'b0);
        wr(`TPM_IDX_PRESCALER, 8'h09);
        t0 = tw;
        wr(`TPM_IDX_CTRL, 8'h41);
        wait_irq(1'b0);
        chk("restart time", 32'd55, 32'(tr - t0));
        wr(`TPM_IDX_MDATA_LO, 8'h04);
        wr(`TPM_IDX_CTRL, 8'h41);
        wait_irq(1'b0);
        t0 = tr;
        wr(`TPM_IDX_CTRL, 8'h41);
        wait_irq(1'b0);
        chk("low period", 32'd250, 32'(tr - t0));
        wr(`TPM_IDX_CTRL, 8'h00);
        rc("stopped low", `TPM_IDX_CNT_LO, 8'h00);
    endtask
    task automatic t_word;
        wr(`TPM_IDX_PRESCALER, 8'h00);
        wr(`TPM_IDX_MDATA_HI, 8'h20);
        wr(`TPM_IDX_CTRL, 8'h84);
        wait_irq(1'b1);
        t0 = tr;
        wr(`TPM_IDX_CTRL, 8'h84);
        wait_irq(1'b1);
        chk("high period", 32'd165, 32'(tr - t0));
        wr(`TPM_IDX_CTRL, 8'h00);
        wr(`TPM_IDX_MDATA_LO, 8'h02);
        wr(`TPM_IDX_MDATA_HI, 8'h01);
        wr(`TPM_IDX_CTRL, 8'hE5);
        wait_irq(1'b1);
        t0 = tr;
        wr(`TPM_IDX_CTRL, 8'hE5);
        wait_irq(1'b1);
        chk("word period", 32'd1295, 32'(tr - t0));
        chk("both flags", 32'h1, {31'h0, low_irq});
        wr(`TPM_IDX_CTRL, 8'h00);
    endtask
    task automatic t_event;
        wr(`TPM_IDX_IRQ_STATUS, 8'h07);
        wr(`TPM_IDX_MDATA_LO, 8'hFF);
        wr(`TPM_IDX_CTRL, 8'h50);
        repeat (3) pulse(1'b0);
        pulse(1'b1);
        rc("event count", `TPM_IDX_CNT_LO, 8'h04);
        rc("capture low", `TPM_IDX_CAP_LO, 8'h03);
        rc("capture high", `TPM_IDX_CAP_HI, 8'h00);
        chk("masked irq", 32'h0, {31'h0, irq});
        rc("status", `TPM_IDX_IRQ_STATUS, 8'h04);
        wr(`TPM_IDX_IRQ_MASK, 8'h04);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`TPM_IDX_IRQ_STATUS, 8'h04);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`TPM_IDX_CNT_LO, 8'hFF);
        wr(`TPM_IDX_CAP_LO, 8'h55);
        rc("count kept", `TPM_IDX_CNT_LO, 8'h04);
        rc("capture kept", `TPM_IDX_CAP_LO, 8'h03);
        wr(`TPM_IDX_EVSEL, 8'h01);
        pulse(1'b1);
        rc("pin b off", `TPM_IDX_CNT_LO, 8'h04);
    endtask
    // Word mode on events: 257 events wrap the low byte once, so the
    // last capture sees a nonzero high byte
    task automatic t_wordev;
        wr(`TPM_IDX_CTRL, 8'h00);
        wr(`TPM_IDX_MDATA_HI, 8'hFF);
        wr(`TPM_IDX_CTRL, 8'hF0);
        repeat (257) pulse(1'b0);
        rc("word events low", `TPM_IDX_CNT_LO, 8'h01);
        rc("word events high", `TPM_IDX_CNT_HI, 8'h01);
        rc("capture word high", `TPM_IDX_CAP_HI, 8'h01);
        rc("capture word low", `TPM_IDX_CAP_LO, 8'h00);
        wr(`TPM_IDX_CTRL, 8'h00);
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        @(posedge sys_clk_in);
        t_reset();
        t_prescale();
        t_word();
        t_event();
        t_wordev();
        stop_test();
    end
endmodule
`default_nettype wire

// [verif/tpm_timer0_checker.sv]
// Port-side assertions for timer 0, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module tpm_timer0_checker (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [17:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic low_irq_req_out,
    input wire logic high_irq_req_out,
    input wire logic irq_out
);
    // ==========
    // One clock domain, so one default clocking and reset
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // ==========
    // Bus handshake: exactly one wait cycle, none while idle
    wait_once_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out)
        else $error("waitrequest held past one cycle");
    idle_nowait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest without a request");
    rd_upper_a: assert property (avs_read_in && !avs_waitrequest_out
        |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[1:0] != 2'b00 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    // Read data must not drift between reads, software may sample late
    rd_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
        else $error("read data changed without a read");

    // ==========
    // Flags, enables, status and mask fall only through a software write
    low_clear_a: assert property ($fell(low_irq_req_out)
        |-> $past(avs_write_in && !avs_waitrequest_out))
        else $error("low request fell without a write");
    high_clear_a: assert property ($fell(high_irq_req_out)
        |-> $past(avs_write_in && !avs_waitrequest_out))
        else $error("high request fell without a write");
    irq_clear_a: assert property ($fell(irq_out)
        |-> $past(avs_write_in && !avs_waitrequest_out))
        else $error("interrupt fell without a write");
endmodule

bind tpm_timer0 tpm_timer0_checker u_tpm_timer0_checker (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .low_irq_req_out(low_irq_req_out), .high_irq_req_out(high_irq_req_out), .irq_out(irq_out)
);
`default_nettype wire
